// ===== core/misp_params.svh
`ifndef MISP_PARAMS_SVH
`define MISP_PARAMS_SVH

// system clock period, ns
`define MISP_SYS_CLK_NS      20
// spike suppression on the bus clock pin, ns
`define MISP_SPIKE_NS        50
// data hold after a falling bus clock edge, ns
`define MISP_HOLD_NS         300
// stream clock edges spent synchronising after power-up
`define MISP_SYNC_EDGES      9
// bit slots per streamed byte: eight data plus one null
`define MISP_DATA_BITS       8
`define MISP_SLOTS_PER_BYTE  9
// array size and starting read address
`define MISP_ARRAY_BYTES     128
`define MISP_START_ADDR      0
`define MISP_FIFO_DEPTH      16

`endif

// ===== core/misp_pkg.sv
package misp_pkg;

	typedef enum logic [0:0] {
		MISP_LK_SYNC  = 1'b0,
		MISP_LK_SHIFT = 1'b1
	} misp_lk_state_e;

	typedef logic [7:0] misp_byte_t;

endpackage

// ===== core/misp_fifo.sv
`timescale 1ns/100ps
`default_nettype none

module misp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             sys_clk,
	input  wire logic             reset_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_ff;
	logic [AW-1:0]    rd_ptr_ff;
	logic [AW:0]      count_ff;
	logic             push;
	logic             pop;

	assign in_ready  = (count_ff != (AW+1)'(DEPTH));
	assign out_valid = (count_ff != '0);
	assign out_data  = mem[rd_ptr_ff];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	always_ff @(posedge sys_clk) begin
		if (push)
			mem[wr_ptr_ff] <= in_data;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
		end else begin
			if (push)
				wr_ptr_ff <= bump(wr_ptr_ff);
			if (pop)
				rd_ptr_ff <= bump(rd_ptr_ff);
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			count_ff <= '0;
		else if (push && !pop)
			count_ff <= count_ff + 1'b1;
		else if (pop && !push)
			count_ff <= count_ff - 1'b1;
	end

endmodule

`default_nettype wire

// ===== core/misp_stream_port.sv
// Summary of operation
// R1: after power-up the port is in streaming mode without any command
// R2: both modes share one data line; each mode has its own clock input
// R3: a valid falling edge on the bus clock pin switches to bidirectional
// R4: bidirectional mode is left only by a new power-up
// R5: host holds the bus clock pin high while streaming is wanted
// R6: one new stream bit per rising stream clock edge
// R7: eight data bits per byte, then a ninth null bit slot
// R8: each byte goes out most significant bit first
// R9: consecutive addresses, wrapping from last to first without pause
// R10: nine stream clock cycles synchronise the port after power-up
// R11: data line stays released during synchronisation
// R12: tenth rising edge drives the first bit, a byte's msb
// R13: starting byte address after power-up is undefined
// R14: bidirectional data changes wait 300 ns after falling bus clock
// R15: on mode switch the stream drive stops and the line is released
`timescale 1ns/100ps
`default_nettype none
`include "misp_params.svh"

module misp_stream_port #(
	parameter int ARRAY_BYTES = `MISP_ARRAY_BYTES,
	parameter int START_ADDR  = `MISP_START_ADDR,
	parameter int FIFO_DEPTH  = `MISP_FIFO_DEPTH
) (
	input  wire logic                           sys_clk,
	input  wire logic                           reset_n,
	input  wire logic                           stream_clock_write_guard_pin,
	input  wire logic                           bidir_bus_clock_pin,
	input  wire logic                           shared_monitor_data_line_i,
	output logic                                shared_monitor_data_line_o,
	output logic                                shared_monitor_data_line_oe,
	input  wire logic                           slave_pull_low,
	input  wire logic                           mem_wr_en,
	input  wire logic [$clog2(ARRAY_BYTES)-1:0] mem_wr_addr,
	input  wire logic [7:0]                     mem_wr_data,
	output logic                                bidir_mode,
	output logic                                data_line_level
);

	localparam int AW = $clog2(ARRAY_BYTES);

	function automatic int ceil_cycles(input int ns);
		ceil_cycles = (ns + `MISP_SYS_CLK_NS - 1) / `MISP_SYS_CLK_NS;
	endfunction

	localparam int SPIKE_CYC = ceil_cycles(`MISP_SPIKE_NS);
	localparam int HOLD_CYC  = ceil_cycles(`MISP_HOLD_NS);

	// system clock domain
	logic [7:0]     mem [ARRAY_BYTES];
	logic [AW-1:0]  rd_addr_ff;
	logic           bclk_s1_ff;
	logic           bclk_s2_ff;
	logic           bclk_filt_ff;
	logic [3:0]     filt_cnt_ff;
	logic           bclk_fall;
	logic           mode_ff;
	logic           req_s1_ff;
	logic           req_s2_ff;
	logic           req_seen_ff;
	logic           ack_ff;
	misp_pkg::misp_byte_t xfer_byte_ff;
	logic           pull_s1_ff;
	logic           pull_s2_ff;
	logic [4:0]     hold_cnt_ff;
	logic           slave_pull_ff;
	logic           pin_oe_ff;
	logic           pin_o_ff;
	logic           line_s1_ff;
	logic           line_s2_ff;
	logic           fifo_in_ready;
	logic           fifo_out_valid;
	logic           fifo_pop;
	misp_pkg::misp_byte_t fifo_out_data;
	misp_pkg::misp_lk_state_e lk_state_ff;
	logic [3:0]     lk_cnt_ff;
	logic           lk_req_ff;
	logic           lk_pull_ff;
	logic           lk_mode_s1_ff;
	logic           lk_mode_s2_ff;
	logic           lk_ack_s1_ff;
	logic           lk_ack_s2_ff;
	logic           lk_ack_seen_ff;
	misp_pkg::misp_byte_t lk_next_ff;
	misp_pkg::misp_byte_t lk_shift_ff;

	always_ff @(posedge sys_clk) begin
		if (mem_wr_en)
			mem[mem_wr_addr] <= mem_wr_data;
	end

	// reader keeps the fifo topped up; stalls when it is full
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_addr_ff <= AW'(START_ADDR); // R13
		end else if (!mode_ff && fifo_in_ready) begin
			if (rd_addr_ff == AW'(ARRAY_BYTES - 1))
				rd_addr_ff <= '0; // R9
			else
				rd_addr_ff <= rd_addr_ff + 1'b1; // R9
		end
	end

	misp_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.reset_n   (reset_n),
		.in_valid  (!mode_ff),
		.in_ready  (fifo_in_ready),
		.in_data   (mem[rd_addr_ff]),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data)
	);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			bclk_s1_ff <= 1'b1;
			bclk_s2_ff <= 1'b1;
			line_s1_ff <= 1'b1;
			line_s2_ff <= 1'b1;
		end else begin
			bclk_s1_ff <= bidir_bus_clock_pin;
			bclk_s2_ff <= bclk_s1_ff;
			line_s1_ff <= shared_monitor_data_line_i;
			line_s2_ff <= line_s1_ff;
		end
	end

	// short spikes on the bus clock must not flip the mode
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			bclk_filt_ff <= 1'b1;
			filt_cnt_ff  <= '0;
		end else if (bclk_s2_ff == bclk_filt_ff) begin
			filt_cnt_ff <= '0;
		end else if (filt_cnt_ff == 4'(SPIKE_CYC - 1)) begin
			bclk_filt_ff <= bclk_s2_ff;
			filt_cnt_ff  <= '0;
		end else begin
			filt_cnt_ff <= filt_cnt_ff + 1'b1;
		end
	end

	assign bclk_fall = bclk_filt_ff && (bclk_s2_ff == 1'b0)
		&& (filt_cnt_ff == 4'(SPIKE_CYC - 1));

	// only reset_n, i.e. power-up, clears the mode
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			mode_ff <= 1'b0; // R1
		else if (bclk_fall)
			mode_ff <= 1'b1; // R3 R4
	end

	// byte handshake: link toggles req, this side answers with ack
	assign fifo_pop = (req_s2_ff != req_seen_ff) && fifo_out_valid;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			req_s1_ff    <= 1'b0;
			req_s2_ff    <= 1'b0;
			req_seen_ff  <= 1'b0;
			ack_ff       <= 1'b0;
			xfer_byte_ff <= '0;
		end else begin
			req_s1_ff <= lk_req_ff;
			req_s2_ff <= req_s1_ff;
			if (fifo_pop) begin
				req_seen_ff  <= req_s2_ff;
				xfer_byte_ff <= fifo_out_data;
				ack_ff       <= ~ack_ff;
			end
		end
	end

	// slave drive may only change once the hold window has passed
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			hold_cnt_ff   <= 5'(HOLD_CYC);
			slave_pull_ff <= 1'b0;
		end else begin
			if (bclk_fall || (bclk_filt_ff && !bclk_s2_ff))
				hold_cnt_ff <= '0; // R14
			else if (hold_cnt_ff != 5'(HOLD_CYC))
				hold_cnt_ff <= hold_cnt_ff + 1'b1;
			if (hold_cnt_ff == 5'(HOLD_CYC) && !(bclk_fall))
				slave_pull_ff <= slave_pull_low; // R14
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pull_s1_ff <= 1'b0;
			pull_s2_ff <= 1'b0;
		end else begin
			pull_s1_ff <= lk_pull_ff;
			pull_s2_ff <= pull_s1_ff;
		end
	end

	// open-drain: the line is only ever pulled low
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_oe_ff <= 1'b0; // R11
			pin_o_ff  <= 1'b0;
		end else begin
			pin_o_ff <= 1'b0;
			if (mode_ff)
				pin_oe_ff <= slave_pull_ff; // R2 R15
			else
				pin_oe_ff <= pull_s2_ff; // R2
		end
	end

	assign shared_monitor_data_line_oe = pin_oe_ff;
	assign shared_monitor_data_line_o  = pin_o_ff;
	assign bidir_mode                  = mode_ff;
	assign data_line_level             = line_s2_ff;

	// stream clock domain

	always_ff @(posedge stream_clock_write_guard_pin or negedge reset_n) begin
		if (!reset_n) begin
			lk_mode_s1_ff  <= 1'b0;
			lk_mode_s2_ff  <= 1'b0;
			lk_ack_s1_ff   <= 1'b0;
			lk_ack_s2_ff   <= 1'b0;
			lk_ack_seen_ff <= 1'b0;
			lk_next_ff     <= '0;
		end else begin
			lk_mode_s1_ff <= mode_ff;
			lk_mode_s2_ff <= lk_mode_s1_ff;
			lk_ack_s1_ff  <= ack_ff;
			lk_ack_s2_ff  <= lk_ack_s1_ff;
			// xfer_byte_ff is stable until the next request
			if (lk_ack_s2_ff != lk_ack_seen_ff) begin
				lk_ack_seen_ff <= lk_ack_s2_ff;
				lk_next_ff     <= xfer_byte_ff;
			end
		end
	end

	// a byte is fetched one whole byte time before it is needed
	always_ff @(posedge stream_clock_write_guard_pin or negedge reset_n) begin
		if (!reset_n) begin
			lk_state_ff <= misp_pkg::MISP_LK_SYNC; // R1
			lk_cnt_ff   <= '0;
			lk_req_ff   <= 1'b0;
			lk_pull_ff  <= 1'b0;
			lk_shift_ff <= '0;
		end else if (lk_mode_s2_ff) begin
			lk_pull_ff <= 1'b0; // R15
		end else begin
			case (lk_state_ff)
			misp_pkg::MISP_LK_SYNC: begin
				lk_pull_ff <= 1'b0; // R11
				if (lk_cnt_ff == 4'd0)
					lk_req_ff <= ~lk_req_ff;
				if (lk_cnt_ff == 4'(`MISP_SYNC_EDGES - 1)) begin // R10
					lk_state_ff <= misp_pkg::MISP_LK_SHIFT;
					lk_cnt_ff   <= '0;
				end else begin
					lk_cnt_ff <= lk_cnt_ff + 1'b1;
				end
			end
			misp_pkg::MISP_LK_SHIFT: begin
				if (lk_cnt_ff == 4'd0) begin
					lk_shift_ff <= lk_next_ff << 1;
					lk_pull_ff  <= ~lk_next_ff[7]; // R8 R12
					lk_req_ff   <= ~lk_req_ff;
				end else if (lk_cnt_ff < 4'(`MISP_DATA_BITS)) begin
					lk_shift_ff <= lk_shift_ff << 1;
					lk_pull_ff  <= ~lk_shift_ff[7]; // R6 R8
				end else begin
					lk_pull_ff <= 1'b0; // R7
				end
				if (lk_cnt_ff == 4'(`MISP_SLOTS_PER_BYTE - 1))
					lk_cnt_ff <= '0; // R7 R9
				else
					lk_cnt_ff <= lk_cnt_ff + 1'b1; // R6
			end
			default: begin
				lk_state_ff <= misp_pkg::MISP_LK_SYNC;
				lk_cnt_ff   <= '0;
			end
			endcase
		end
	end

endmodule

`default_nettype wire

// ===== testbench/misp_port_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module misp_port_monitor (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic stream_clock_write_guard_pin,
	input wire logic bidir_bus_clock_pin,
	input wire logic shared_monitor_data_line_i,
	input wire logic shared_monitor_data_line_oe,
	input wire logic slave_pull_low,
	input wire logic bidir_mode,
	input wire logic data_line_level
);
	logic [3:0] edge_cnt_ff;
	// saturates: only the first ten stream edges matter
	always_ff @(posedge stream_clock_write_guard_pin or negedge reset_n) begin
		if (!reset_n)
			edge_cnt_ff <= 4'h0;
		else if (edge_cnt_ff != 4'hf)
			edge_cnt_ff <= edge_cnt_ff + 4'h1;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	property p_sticky;
		bidir_mode |=> bidir_mode;
	endproperty
	a_sticky: assert property (p_sticky) else $error("mode dropped");
	property p_cause;
		$rose(bidir_mode) |-> !$past(bidir_bus_clock_pin, 3);
	endproperty
	a_cause: assert property (p_cause) else $error("mode uncaused");
	property p_bound;
		!bidir_bus_clock_pin [*8] |-> bidir_mode;
	endproperty
	a_bound: assert property (p_bound) else $error("mode late");
	property p_stay;
		(bidir_bus_clock_pin && !bidir_mode) [*8] |=> !bidir_mode;
	endproperty
	a_stay: assert property (p_stay) else $error("mode spurious");
	property p_sync;
		edge_cnt_ff < 4'ha && !bidir_mode |-> !shared_monitor_data_line_oe;
	endproperty
	a_sync: assert property (p_sync) else $error("line driven early");
	property p_slave;
		(bidir_mode && !slave_pull_low) [*8] |-> !shared_monitor_data_line_oe;
	endproperty
	a_slave: assert property (p_slave) else $error("stream still on");
	property p_hold;
		bidir_mode && $fell(bidir_bus_clock_pin)
			|-> ##8 $stable(shared_monitor_data_line_oe) [*8];
	endproperty
	a_hold: assert property (p_hold) else $error("hold broken");
	property p_level;
		$stable(shared_monitor_data_line_i) [*4]
			|-> data_line_level == shared_monitor_data_line_i;
	endproperty
	a_level: assert property (p_level) else $error("level stale");
endmodule
bind misp_stream_port misp_port_monitor u_misp_port_monitor (
	.sys_clk(sys_clk),
	.reset_n(reset_n),
	.stream_clock_write_guard_pin(stream_clock_write_guard_pin),
	.bidir_bus_clock_pin(bidir_bus_clock_pin),
	.shared_monitor_data_line_i(shared_monitor_data_line_i),
	.shared_monitor_data_line_oe(shared_monitor_data_line_oe),
	.slave_pull_low(slave_pull_low),
	.bidir_mode(bidir_mode),
	.data_line_level(data_line_level)
);
`default_nettype wire

// ===== testbench/misp_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module misp_host_model (
	output logic      stream_clk,
	output logic      bus_clk,
	input wire logic  line_oe,
	output logic      line_level
);
	// open drain with pull-up: only the enable can pull the line low
	assign line_level = ~line_oe;
	initial begin
		stream_clk = 1'b0;
		bus_clk = 1'b1;
	end
	// one stream edge at 32 ns period; clock stands still afterwards
	task automatic pulse;
		stream_clk = 1'b1;
		#16;
		stream_clk = 1'b0;
		#16;
	endtask
	task automatic set_bus(input logic v);
		bus_clk = v;
	endtask
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam int NB = 4;
	logic       sys_clk, reset_n, vclk, dclk, line, oe, o, pull, mode, lvl;
	logic       wr_en;
	logic [1:0] wr_addr;
	logic [7:0] wr_data;
	int         err_total, n_checks;
	logic [7:0] mem [NB] = '{8'hb4, 8'h3c, 8'h0f, 8'h81};
	misp_stream_port #(.ARRAY_BYTES(NB)) u_misp_stream_port (
		.sys_clk(sys_clk), .reset_n(reset_n),
		.stream_clock_write_guard_pin(vclk), .bidir_bus_clock_pin(dclk),
		.shared_monitor_data_line_i(line), .shared_monitor_data_line_o(o),
		.shared_monitor_data_line_oe(oe), .slave_pull_low(pull),
		.mem_wr_en(wr_en), .mem_wr_addr(wr_addr), .mem_wr_data(wr_data),
		.bidir_mode(mode), .data_line_level(lvl)
	);
	misp_host_model u_misp_host_model (
		.stream_clk(vclk), .bus_clk(dclk), .line_oe(oe),
		.line_level(line)
	);
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		if (err_total == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// crossing latency is several system cycles, so wait before sampling
	task automatic bit_in(output logic b);
		u_misp_host_model.pulse();
		tick(6);
		b = line;
	endtask
	task automatic t_stream(input int nb);
		logic       b;
		logic [7:0] v;
		int         a;
		for (int i = 0; i < 9; i++) begin
			bit_in(b);
			check({7'h0, b}, 8'h01);
		end
		a = -1;
		for (int k = 0; k < nb; k++) begin
			for (int i = 0; i < 9; i++) begin
				bit_in(b);
				if (i < 8)
					v = {v[6:0], b};
				else
					check({7'h0, b}, 8'h01);
			end
			for (int j = 0; j < NB && a < 0; j++)
				if (mem[j] === v)
					a = j;
			check(v, mem[a]);
			a = (a + 1) % NB;
		end
	endtask
	task automatic t_spike;
		u_misp_host_model.set_bus(1'b0);
		tick(1);
		u_misp_host_model.set_bus(1'b1);
		tick(12);
		check({7'h0, mode}, 8'h00);
	endtask
	task automatic t_switch;
		logic b;
		int   n;
		// switch in mid-byte, while a zero bit pulls the line
		n = 0;
		b = 1'b1;
		while (b !== 1'b0 && n < 9) begin
			bit_in(b);
			n++;
		end
		check({7'h0, b}, 8'h00);
		check({7'h0, o}, 8'h00);
		u_misp_host_model.set_bus(1'b0);
		n = 0;
		while (mode !== 1'b1 && n < 20) begin
			tick(1);
			n++;
		end
		check({7'h0, mode}, 8'h01);
		if (n == 20)
			test_done();
		tick(4);
		check({7'h0, oe}, 8'h00);
		u_misp_host_model.set_bus(1'b1);
		repeat (12) bit_in(b);
		check({7'h0, b}, 8'h01);
		check({7'h0, mode}, 8'h01);
		u_misp_host_model.set_bus(1'b0);
		tick(9);
		pull = 1'b1;
		tick(6);
		check({7'h0, oe}, 8'h00);
		tick(14);
		check({7'h0, line}, 8'h00);
		check({7'h0, lvl}, 8'h00);
		u_misp_host_model.set_bus(1'b1);
		tick(2);
		pull = 1'b0;
		tick(4);
		check({7'h0, line}, 8'h01);
		check({7'h0, lvl}, 8'h01);
	endtask
	initial begin
		reset_n = 1'b0;
		pull = 1'b0;
		wr_en = 1'b0;
		wr_addr = 2'h0;
		wr_data = 8'h00;
		err_total = 0;
		n_checks = 0;
		// array loads during reset: the reader fills the fifo once reset is released
		for (int j = 0; j < NB; j++) begin
			wr_en = 1'b1;
			wr_addr = j[1:0];
			wr_data = mem[j];
			tick(1);
		end
		wr_en = 1'b0;
		tick(12);
		reset_n = 1'b1;
		tick(2);
		t_stream(NB + 1);
		t_spike();
		t_switch();
		// mid-run reset stands in for a new power-up
		reset_n = 1'b0;
		tick(16);
		reset_n = 1'b1;
		tick(2);
		check({7'h0, mode}, 8'h00);
		t_stream(2);
		test_done();
	end
endmodule
`default_nettype wire
